//--- axis_extended_status.sv
// Behaviour
// - State code 0 stopped, 1 pulser, 2 start
// - State code 3 sync wait, 4 axis wait
// - Codes 5 DEVIATION_CLEAR_OUT, 6 dir, 7 backlash, B accel
// - Bit 4 shows motion direction
// - Bits 5-7 show start, stop, emergency inputs
// - Bits 8-10 show override, deviation clear, index
// - Bits 11-12 show pulser plus, minus
// - Bits 13-14 show counter reset, latch
// - Bits 15 and 17 show slow-down inputs
// - Bit 16 shows positioning complete input
// - Bits 18-19 show comparator-5 pre-register state
// - Bits 20-21 show operation pre-register state
// - Bits 22-23 show latched slow-down flags
// - Word read-only, bits 24-31 zero
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module axis_extended_status
  import axis_status_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] operation_state_code,
  input wire logic motion_direction_flag,
  input wire logic deviation_clear_out,
  input wire logic [1:0] cmp5_prereg_state,
  input wire logic [1:0] op_prereg_state,
  input wire logic plus_slowdown_latched,
  input wire logic minus_slowdown_latched,
  input wire logic shared_start_in_n,
  input wire logic shared_stop_in_n,
  input wire logic shared_emergency_in_n,
  input wire logic target_override_in,
  input wire logic encoder_index_in,
  input wire logic [1:0] manual_pulser_way_in,
  input wire logic counter_reset_in,
  input wire logic counter_latch_in,
  input wire logic [1:0] slowdown_in,
  input wire logic positioning_complete_in
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [SENSE_W-1:0] sense;
    logic filt_en;
    logic [31:0] rdata;
    logic err;
  } regs_s;

  regs_s q;
  regs_s d;

  logic [31:0] status_w;
  logic [NUM_PINS-1:0] pins;
  logic setup_ph;
  logic access_ph;
  logic sel_status;
  logic sel_sense;
  logic sel_filter;

  // ==========================================================================
  // Pin conditioning
  cond_if #(.W(NUM_PINS)) cin ();

  always_comb begin
    pins = '0;
    pins[PIN_START] = shared_start_in_n;
    pins[PIN_STOP] = shared_stop_in_n;
    pins[PIN_EMG] = shared_emergency_in_n;
    pins[PIN_PCS] = target_override_in;
    pins[PIN_EZ] = encoder_index_in;
    pins[PIN_DRP] = manual_pulser_way_in[0];
    pins[PIN_DRM] = manual_pulser_way_in[1];
    pins[PIN_CLR] = counter_reset_in;
    pins[PIN_LTC] = counter_latch_in;
    pins[PIN_PSD] = slowdown_in[0];
    pins[PIN_INP] = positioning_complete_in;
    pins[PIN_MSD] = slowdown_in[1];
  end

  assign cin.raw = pins;
  // Fixed low-true pins, others per sense
  assign cin.polarity = {q.sense, {NUM_FIXED{1'b1}}};
  assign cin.filt_en = q.filt_en;

  input_conditioner #(
    .W(NUM_PINS),
    .FL(FILTER_LEN)
  ) u_cond (
    .pclk(pclk),
    .presetn(presetn),
    .c(cin)
  );

  // ==========================================================================
  // Status word assembly
  always_comb begin
    status_w = '0;
    status_w[POS_STATE +: 4] = operation_state_code;
    status_w[POS_DIR] = motion_direction_flag;
    status_w[POS_START] = cin.level[PIN_START];
    status_w[POS_STOP] = cin.level[PIN_STOP];
    status_w[POS_EMG] = cin.level[PIN_EMG];
    status_w[POS_PCS] = cin.level[PIN_PCS];
    status_w[POS_ERC] = deviation_clear_out;
    status_w[POS_EZ] = cin.level[PIN_EZ];
    status_w[POS_DRP] = cin.level[PIN_DRP];
    status_w[POS_DRM] = cin.level[PIN_DRM];
    status_w[POS_CLR] = cin.level[PIN_CLR];
    status_w[POS_LTC] = cin.level[PIN_LTC];
    status_w[POS_PSD] = cin.level[PIN_PSD];
    status_w[POS_MSD] = cin.level[PIN_MSD];
    status_w[POS_INP] = cin.level[PIN_INP];
    status_w[POS_PFC +: 2] = cmp5_prereg_state;
    status_w[POS_PFM +: 2] = op_prereg_state;
    status_w[POS_PLUS_SLOWDOWN_LATCHED] = plus_slowdown_latched;
    status_w[POS_MINUS_SLOWDOWN_LATCHED] = minus_slowdown_latched;
    status_w[31:POS_ZERO] = '0;
  end

  // ==========================================================================
  // APB slave
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign sel_status = (paddr == OFF_STATUS);
  assign sel_sense = (paddr == OFF_SENSE);
  assign sel_filter = (paddr == OFF_FILTER);

  // Zero wait states; read data is captured in setup so it is a flop
  assign pready = 1'b1;
  assign prdata = q.rdata;
  assign pslverr = q.err;

  always_comb begin
    d = q;
    if (setup_ph) begin
      d.rdata = '0;
      d.err = 1'b0;
      if (sel_status) begin
        d.rdata = pwrite ? '0 : status_w;
        d.err = pwrite;
      end else if (sel_sense) begin
        d.rdata[SENSE_W-1:0] = pwrite ? '0 : q.sense;
      end else if (sel_filter) begin
        d.rdata[0] = pwrite ? 1'b0 : q.filt_en;
      end else begin
        d.err = 1'b1;
      end
    end
    if (access_ph && pwrite) begin
      // Sense and filter are software controls
      if (sel_sense) begin
        if (pstrb[0]) begin
          d.sense[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
          d.sense[SENSE_W-1:8] = pwdata[SENSE_W-1:8];
        end
      end else if (sel_filter && pstrb[0]) begin
        d.filt_en = pwdata[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.sense <= SENSE_RST;
      q.filt_en <= FILTER_RST;
      q.rdata <= '0;
      q.err <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence read_status;
    psel && !penable && !pwrite && (paddr == OFF_STATUS);
  endsequence

  a_state_stopped: assert property (
    read_status ##0 (operation_state_code == OP_STOPPED) |=> prdata[3:0] == 4'h0
  ) else $error("stopped code wrong");

  a_state_sync: assert property (
    read_status ##0 (operation_state_code == OP_WAIT_SYNC) |=> prdata[3:0] == 4'h3
  ) else $error("sync wait code wrong");

  a_state_accel: assert property (
    read_status ##0 (operation_state_code == OP_ACCEL) |=> prdata[3:0] == 4'hB
  ) else $error("accel code wrong");

  a_state_pulser: assert property (
    read_status ##0 (operation_state_code == OP_WAIT_PULSER) |=> prdata[3:0] == 4'h1
  ) else $error("pulser wait code wrong");

  a_state_start: assert property (
    read_status ##0 (operation_state_code == OP_WAIT_START) |=> prdata[3:0] == 4'h2
  ) else $error("start wait code wrong");

  a_state_axis: assert property (
    read_status ##0 (operation_state_code == OP_WAIT_AXIS) |=> prdata[3:0] == 4'h4
  ) else $error("axis wait code wrong");

  a_state_erc: assert property (
    read_status ##0 (operation_state_code == OP_WAIT_ERC) |=> prdata[3:0] == 4'h5
  ) else $error("deviation timer code wrong");

  a_state_dirwait: assert property (
    read_status ##0 (operation_state_code == OP_WAIT_DIR) |=> prdata[3:0] == 4'h6
  ) else $error("direction timer code wrong");

  a_state_backlash: assert property (
    read_status ##0 (operation_state_code == OP_BACKLASH) |=> prdata[3:0] == 4'h7
  ) else $error("backlash code wrong");

  a_dir_read: assert property (
    read_status |=> prdata[POS_DIR] == $past(motion_direction_flag)
  ) else $error("direction bit wrong");

  a_start_seen: assert property (
    (!shared_start_in_n)[*8] ##0 read_status |=> prdata[POS_START]
  ) else $error("start input not shown");

  a_emg_clear: assert property (
    shared_emergency_in_n[*8] ##0 read_status |=> !prdata[POS_EMG]
  ) else $error("emergency shown while released");

  a_erc_read: assert property (
    read_status |=> prdata[POS_ERC] == $past(deviation_clear_out)
  ) else $error("deviation clear bit wrong");

  a_pulser_plus: assert property (
    (manual_pulser_way_in[0] && !q.sense[PIN_DRP-NUM_FIXED])[*8] ##0 read_status
      |=> prdata[POS_DRP]
  ) else $error("pulser plus not shown");

  a_latch_in: assert property (
    (counter_latch_in && !q.sense[PIN_LTC-NUM_FIXED])[*8] ##0 read_status
      |=> prdata[POS_LTC]
  ) else $error("latch input not shown");

  a_minus_sd: assert property (
    (slowdown_in[1] && !q.sense[PIN_MSD-NUM_FIXED])[*8] ##0 read_status
      |=> prdata[POS_MSD]
  ) else $error("minus slow-down not shown");

  a_inpos_in: assert property (
    (positioning_complete_in && !q.sense[PIN_INP-NUM_FIXED])[*8] ##0 read_status
      |=> prdata[POS_INP]
  ) else $error("in-position not shown");

  a_stop_seen: assert property (
    (!shared_stop_in_n)[*8] ##0 read_status |=> prdata[POS_STOP]
  ) else $error("stop input not shown");

  a_override_in: assert property (
    (target_override_in && !q.sense[PIN_PCS-NUM_FIXED])[*8] ##0 read_status
      |=> prdata[POS_PCS]
  ) else $error("override input not shown");

  a_pulser_minus: assert property (
    (manual_pulser_way_in[1] && !q.sense[PIN_DRM-NUM_FIXED])[*8] ##0 read_status
      |=> prdata[POS_DRM]
  ) else $error("pulser minus not shown");

  a_clr_in: assert property (
    (counter_reset_in && !q.sense[PIN_CLR-NUM_FIXED])[*8] ##0 read_status
      |=> prdata[POS_CLR]
  ) else $error("counter reset input not shown");

  a_plus_sd: assert property (
    (slowdown_in[0] && !q.sense[PIN_PSD-NUM_FIXED])[*8] ##0 read_status
      |=> prdata[POS_PSD]
  ) else $error("plus slow-down not shown");

  a_cmp5_state: assert property (
    read_status |=> prdata[POS_PFC +: 2] == $past(cmp5_prereg_state)
  ) else $error("cmp5 pre-register state wrong");

  a_op_state: assert property (
    read_status |=> prdata[POS_PFM +: 2] == $past(op_prereg_state)
  ) else $error("operation pre-register state wrong");

  a_sd_latched: assert property (
    read_status |=> prdata[POS_MINUS_SLOWDOWN_LATCHED:POS_PLUS_SLOWDOWN_LATCHED]
      == $past({minus_slowdown_latched, plus_slowdown_latched})
  ) else $error("latched slow-down wrong");

  a_upper_zero: assert property (
    prdata[31:POS_ZERO] == 8'h00
  ) else $error("upper status bits not zero");

  a_status_ro: assert property (
    psel && !penable && pwrite && (paddr == OFF_STATUS) |=> pslverr
  ) else $error("status write not refused");

  // Inverted sense masks high index pin
  a_sense_inv: assert property (
    (encoder_index_in && q.sense[PIN_EZ-NUM_FIXED])[*8] ##0 read_status
      |=> !prdata[POS_EZ]
  ) else $error("index sense not applied");

endmodule : axis_extended_status

//--- axis_status_pkg.sv
package axis_status_pkg;

  // ==========================================================================
  // Register map
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_SENSE = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_FILTER = 12'h008;

  // ==========================================================================
  // Conditioned pin inputs, index in the pin vector
  localparam int NUM_PINS = 12;
  localparam int PIN_START = 0;
  localparam int PIN_STOP = 1;
  localparam int PIN_EMG = 2;
  localparam int PIN_PCS = 3;
  localparam int PIN_EZ = 4;
  localparam int PIN_DRP = 5;
  localparam int PIN_DRM = 6;
  localparam int PIN_CLR = 7;
  localparam int PIN_LTC = 8;
  localparam int PIN_PSD = 9;
  localparam int PIN_INP = 10;
  localparam int PIN_MSD = 11;
  // Pins below this index are fixed active low
  localparam int NUM_FIXED = 3;
  localparam int SENSE_W = NUM_PINS - NUM_FIXED;

  // ==========================================================================
  // Status word fields
  localparam int POS_STATE = 0;
  localparam int POS_DIR = 4;
  localparam int POS_START = 5;
  localparam int POS_STOP = 6;
  localparam int POS_EMG = 7;
  localparam int POS_PCS = 8;
  localparam int POS_ERC = 9;
  localparam int POS_EZ = 10;
  localparam int POS_DRP = 11;
  localparam int POS_DRM = 12;
  localparam int POS_CLR = 13;
  localparam int POS_LTC = 14;
  localparam int POS_PSD = 15;
  localparam int POS_INP = 16;
  localparam int POS_MSD = 17;
  localparam int POS_PFC = 18;
  localparam int POS_PFM = 20;
  localparam int POS_PLUS_SLOWDOWN_LATCHED = 22;
  localparam int POS_MINUS_SLOWDOWN_LATCHED = 23;
  localparam int POS_ZERO = 24;

  // ==========================================================================
  // Reset values and timing
  localparam logic [SENSE_W-1:0] SENSE_RST = 9'h000;
  localparam logic FILTER_RST = 1'b1;
  localparam int FILTER_LEN = 3;

  // ==========================================================================
  // Operation state codes
  typedef enum logic [3:0] {
    OP_STOPPED = 4'h0,
    OP_WAIT_PULSER = 4'h1,
    OP_WAIT_START = 4'h2,
    OP_WAIT_SYNC = 4'h3,
    OP_WAIT_AXIS = 4'h4,
    OP_WAIT_ERC = 4'h5,
    OP_WAIT_DIR = 4'h6,
    OP_BACKLASH = 4'h7,
    OP_ACCEL = 4'hB
  } op_state_e;

endpackage : axis_status_pkg

//--- cond_if.sv
`timescale 1ns/100ps
interface cond_if #(
  parameter int W = 12
);
  logic [W-1:0] raw;
  logic [W-1:0] polarity;
  logic filt_en;
  logic [W-1:0] level;

  modport conditioner (
    input raw,
    input polarity,
    input filt_en,
    output level
  );

  modport user (
    output raw,
    output polarity,
    output filt_en,
    input level
  );
endinterface : cond_if

//--- input_conditioner.sv
`timescale 1ns/100ps
module input_conditioner
  import axis_status_pkg::*;
#(
  parameter int W = NUM_PINS,
  parameter int FL = FILTER_LEN
) (
  input wire logic pclk,
  input wire logic presetn,
  cond_if.conditioner c
);

  // Shift history needs at least two taps
  if (W < 1 || FL < 2) begin : g_bad_params
    $error("input_conditioner: W must be >= 1 and FL >= 2");
  end

  typedef struct packed {
    logic [W-1:0] sync1;
    logic [W-1:0] sync2;
    logic [FL-1:0][W-1:0] hist;
    logic [W-1:0] level;
  } cond_s;

  cond_s q;
  cond_s d;

  // ==========================================================================
  // Sync, polarity and agreement filter
  always_comb begin
    logic same;
    same = 1'b1;
    d = q;
    d.sync1 = c.raw;
    d.sync2 = q.sync1;
    d.hist = {q.hist[FL-2:0], q.sync2 ^ c.polarity};
    for (int i = 0; i < W; i++) begin
      same = 1'b1;
      for (int k = 1; k < FL; k++) begin
        if (q.hist[k][i] != q.hist[0][i]) begin
          same = 1'b0;
        end
      end
      // With filt_en set, glitches shorter than FL samples never reach software
      if (!c.filt_en || same) begin
        d.level[i] = q.hist[0][i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign c.level = q.level;

endmodule : input_conditioner

//--- sensor_model.sv
`timescale 1ns/100ps
// ==========================================================================
// Sensor and driver pins seen from outside the axis
module sensor_model
  import axis_status_pkg::*;
(
  input wire logic pclk,
  input wire logic [NUM_PINS-1:0] on_req,
  input wire logic [NUM_PINS-1:0] low_act,
  output logic [NUM_PINS-1:0] pin
);
  // Fixed active-low pins idle high
  initial pin = 12'h007;
  always @(posedge pclk) begin
    pin <= on_req ^ low_act;
  end
endmodule : sensor_model

//--- tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("ERROR %s exp %h got %h", nm, ex, got); end end
module tb;
  import axis_status_pkg::*;
  // ==========================================================================
  // Signals
  logic pclk;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] st = 4'h0;
  logic dir = 1'b0;
  logic dev = 1'b0;
  logic [1:0] cmp = 2'h0;
  logic [1:0] opr = 2'h0;
  logic psl = 1'b0;
  logic msl = 1'b0;
  logic [NUM_PINS-1:0] on_v = 12'h000;
  logic [NUM_PINS-1:0] lo_v = 12'h007;
  logic [NUM_PINS-1:0] pins;
  logic [SENSE_W-1:0] sense_v = 9'h000;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int num_checks = 0;
  int posmap[NUM_PINS] = '{5, 6, 7, 8, 10, 11, 12, 13, 14, 15, 16, 17};
  logic [3:0] codes[9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hB};

  sensor_model sens_u (.pclk(pclk), .on_req(on_v), .low_act(lo_v), .pin(pins));

  axis_extended_status dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .operation_state_code(st), .motion_direction_flag(dir),
    .deviation_clear_out(dev), .cmp5_prereg_state(cmp), .op_prereg_state(opr),
    .plus_slowdown_latched(psl), .minus_slowdown_latched(msl),
    .shared_start_in_n(pins[PIN_START]), .shared_stop_in_n(pins[PIN_STOP]),
    .shared_emergency_in_n(pins[PIN_EMG]), .target_override_in(pins[PIN_PCS]),
    .encoder_index_in(pins[PIN_EZ]), .manual_pulser_way_in(pins[PIN_DRM:PIN_DRP]),
    .counter_reset_in(pins[PIN_CLR]), .counter_latch_in(pins[PIN_LTC]),
    .slowdown_in({pins[PIN_MSD], pins[PIN_PSD]}), .positioning_complete_in(pins[PIN_INP])
  );

  // ==========================================================================
  // Clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    results();
  end

  // ==========================================================================
  // Tasks
  task automatic results();
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // Entered right after a rising edge; idle cycle after release avoids double drive
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  function automatic logic [31:0] expw();
    logic [31:0] w;
    logic [NUM_PINS-1:0] seen;
    w = 32'h0000_0000;
    seen = on_v ^ lo_v ^ {sense_v, 3'b111};
    w[3:0] = st;
    w[4] = dir;
    w[9] = dev;
    w[19:18] = cmp;
    w[21:20] = opr;
    w[22] = psl;
    w[23] = msl;
    for (int i = 0; i < NUM_PINS; i++) w[posmap[i]] = seen[i];
    return w;
  endfunction : expw

  // ==========================================================================
  // Tests
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("status reset", expw(), rd)
    apb(1'b0, OFF_SENSE, 32'h0);
    `CHK("sense reset", 32'h0000_0000, rd)
    apb(1'b0, OFF_FILTER, 32'h0);
    `CHK("filter reset", 32'h0000_0001, rd)
    for (int i = 0; i < 9; i++) begin
      st <= codes[i];
      dir <= i[0];
      dev <= ~i[0];
      cmp <= i[1:0];
      opr <= ~i[2:1];
      psl <= i[1];
      msl <= i[2];
      @(posedge pclk);
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK("state dir", {i[0], codes[i]}, rd[4:0])
      `CHK("status core", expw(), rd)
    end
    // Both filter settings, one pin at a time
    for (int f = 1; f >= 0; f--) begin
      apb(1'b1, OFF_FILTER, f);
      for (int i = 0; i < NUM_PINS; i++) begin
        on_v <= 12'h001 << i;
        repeat (10) @(posedge pclk);
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("pin bit", expw(), rd)
      end
      on_v <= 12'h000;
      repeat (10) @(posedge pclk);
    end
    apb(1'b0, OFF_FILTER, 32'h0);
    `CHK("filter wr", 32'h0000_0000, rd)
    // Single-sample pulse must not pass the filter
    apb(1'b1, OFF_FILTER, 32'h0000_0001);
    on_v <= 12'h010;
    @(posedge pclk);
    on_v <= 12'h000;
    repeat (4) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("glitch", 1'b0, rd[POS_EZ])
    // Sense inverted while pins stay electrically low
    apb(1'b1, OFF_SENSE, 32'h0000_01FF);
    `CHK("sense wr err", 1'b0, err)
    sense_v = 9'h1FF;
    lo_v <= 12'h007;
    repeat (10) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("sense status", expw(), rd)
    // Pins high are idle once sense is inverted
    lo_v <= 12'hFFF;
    repeat (10) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("sense idle", expw(), rd)
    pstrb <= 4'h1;
    apb(1'b1, OFF_SENSE, 32'h0);
    apb(1'b0, OFF_SENSE, 32'h0);
    `CHK("sense lane", 32'h0000_0100, rd)
    pstrb <= 4'hF;
    apb(1'b1, OFF_SENSE, 32'h0);
    sense_v = 9'h000;
    lo_v <= 12'h007;
    // Status is read-only
    apb(1'b1, OFF_STATUS, 32'hFFFF_FFFF);
    `CHK("status wr err", 1'b1, err)
    repeat (10) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("status kept", expw(), rd)
    apb(1'b0, 12'h00C, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rd)
    results();
  end
endmodule : tb
